// ### design/adc_mode_timing_control.sv
// Mode and timing control for a successive-approximation converter.
// Assumes an APB master on ref_clk and an analog core that answers each
// conversion clock step with a comparator decision.
//
// What this block does
// - Converter clock is input clock over (divider plus one) times two
// - Wait (startup plus one) times eight converter clocks on wake-up
// - Hold sample phase for (hold plus one) converter clocks
// - Sleep select zero gives normal mode, one gives sleep mode
// - Reduced resolution zero gives 10-bit results, one gives 8-bit
// - Three-bit trigger source picks internal trigger input 0 to 4
// - Mode register fields at bits 0, 3:1, 4, 5, 13:8, 20:16, 27:24
// - Sleep selected while idle takes effect after the next conversion
`timescale 1ns/1ps
module adc_mode_timing_control #(
    parameter int NUM_TRIG = adc_mode_pkg::NUM_TRIGGERS
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [NUM_TRIG-1:0] intTrigger,
    input  wire logic                compareBit,
    output logic                     converterClock,
    output logic                     sampleHold,
    output logic                     coreSleep,
    output logic                     conversionDone
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [31:0]              modeReg, modeNext;
    adc_mode_pkg::mode_cfg_t  cfg;
    logic                     swStartReg, swStartNext;
    logic [31:0]              prdataReg, prdataNext;
    logic                     wrEn, rdEn;

    assign cfg = '{sampleHoldCycles:
                       modeReg[adc_mode_pkg::HOLD_LSB +: 4],
                   startupField:
                       modeReg[adc_mode_pkg::START_LSB +: 5],
                   convClockDivider:
                       modeReg[adc_mode_pkg::DIV_LSB +: 6],
                   sleepSelect:
                       modeReg[adc_mode_pkg::SLEEP_POS],
                   reducedResolutionSelect:
                       modeReg[adc_mode_pkg::RES_POS],
                   triggerSourceSelect:
                       modeReg[adc_mode_pkg::TRIG_SEL_LSB +: 3],
                   hwTriggerEnable:
                       modeReg[adc_mode_pkg::TRIG_EN_POS]};

    assign wrEn    = psel && penable && pwrite;
    assign rdEn    = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign prdata  = prdataReg;
    function automatic logic isMapped(input logic [7:0] a);
        return a == adc_mode_pkg::MODE_CFG_OFFSET ||
               a == adc_mode_pkg::CTRL_OFFSET ||
               a == adc_mode_pkg::STATUS_OFFSET ||
               a == adc_mode_pkg::RESULT_OFFSET;
    endfunction
    assign pslverr = psel && penable && !isMapped(paddr);

    adc_mode_pkg::conv_state_t stateReg, stateNext;
    logic [9:0]  resultReg, resultNext;
    logic        doneReg, doneNext;

    always_comb begin
        modeNext    = modeReg;
        swStartNext = swStartReg;
        prdataNext  = prdataReg;
        if (wrEn && paddr == adc_mode_pkg::MODE_CFG_OFFSET) begin
            modeNext = pwdata & adc_mode_pkg::MODE_CFG_MASK;
        end
        if (wrEn && paddr == adc_mode_pkg::CTRL_OFFSET && pwdata[0]) begin
            swStartNext = 1'b1;
        end else if (stateReg == adc_mode_pkg::ST_HOLD) begin
            swStartNext = 1'b0;
        end
        if (rdEn) begin
            case (paddr)
                adc_mode_pkg::MODE_CFG_OFFSET: prdataNext = modeReg;
                adc_mode_pkg::STATUS_OFFSET:
                    prdataNext = {28'h000_0000, doneReg, coreSleep,
                                  stateReg == adc_mode_pkg::ST_IDLE,
                                  swStartReg};
                adc_mode_pkg::RESULT_OFFSET:
                    prdataNext = {22'h00_0000, resultReg};
                default: prdataNext = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            modeReg    <= adc_mode_pkg::MODE_CFG_RESET;
            swStartReg <= 1'b0;
            prdataReg  <= 32'h0000_0000;
        end else begin
            modeReg    <= modeNext;
            swStartReg <= swStartNext;
            prdataReg  <= prdataNext;
        end
    end

    // ****************************************************************
    // Converter clock divider and trigger edge detect
    // ****************************************************************
    logic [6:0] divCntReg, divCntNext;
    logic       cclkReg, cclkNext;
    logic       tick;
    logic [NUM_TRIG-1:0] trigMeta, trigSync, trigPrev;
    logic       trigSel, trigSelPrev, trigEdge;

    // Toggle every (divider+1) input clocks: full period is twice that
    // Greater-or-equal so a smaller divider written mid-count cannot stall
    assign tick = divCntReg >= {1'b0, cfg.convClockDivider};

    always_comb begin
        divCntNext = tick ? 7'h00 : divCntReg + 7'h01;
        cclkNext   = tick ? !cclkReg : cclkReg;
    end

    // Selects beyond input 4 never fire
    assign trigSel = (int'(cfg.triggerSourceSelect) < NUM_TRIG) ?
                     trigSync[cfg.triggerSourceSelect] : 1'b0;
    assign trigSelPrev = (int'(cfg.triggerSourceSelect) < NUM_TRIG) ?
                     trigPrev[cfg.triggerSourceSelect] : 1'b0;
    assign trigEdge = trigSel && !trigSelPrev;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCntReg <= 7'h00;
            cclkReg   <= 1'b0;
            trigMeta  <= '0;
            trigSync  <= '0;
            trigPrev  <= '0;
        end else begin
            divCntReg <= divCntNext;
            cclkReg   <= cclkNext;
            trigMeta  <= intTrigger;
            trigSync  <= trigMeta;
            trigPrev  <= trigSync;
        end
    end

    // ****************************************************************
    // Conversion sequencer, stepping startup, hold and convert once per converter clock period
    // ****************************************************************
    logic [7:0] stepCntReg, stepCntNext;
    logic       sleepArmReg, sleepArmNext;
    logic       periodEnd;
    logic       startReq;

    assign periodEnd = tick && cclkReg;
    assign startReq  = cfg.hwTriggerEnable ? trigEdge : swStartReg;

    always_comb begin
        stateNext    = stateReg;
        stepCntNext  = stepCntReg;
        resultNext   = resultReg;
        doneNext     = 1'b0;
        sleepArmNext = sleepArmReg;
        if (!cfg.sleepSelect) begin
            sleepArmNext = 1'b0;
        end
        case (stateReg)
            adc_mode_pkg::ST_OFF: begin
                if (!cfg.sleepSelect) begin
                    stateNext   = adc_mode_pkg::ST_STARTUP;
                    stepCntNext = 8'h00;
                end
            end
            adc_mode_pkg::ST_STARTUP: begin
                if (periodEnd) begin
                    stepCntNext = stepCntReg + 8'h01;
                    if (stepCntReg == 8'((cfg.startupField + 6'h01) *
                            adc_mode_pkg::STARTUP_MULT) - 8'h01) begin
                        stateNext = adc_mode_pkg::ST_IDLE;
                    end
                end
            end
            adc_mode_pkg::ST_IDLE: begin
                // Sleep waits for one more conversion after selection
                if (sleepArmReg) begin
                    stateNext = adc_mode_pkg::ST_OFF;
                end else if (startReq) begin
                    stateNext   = adc_mode_pkg::ST_HOLD;
                    stepCntNext = 8'h00;
                end
            end
            adc_mode_pkg::ST_HOLD: begin
                if (periodEnd) begin
                    stepCntNext = stepCntReg + 8'h01;
                    if (stepCntReg == {4'h0, cfg.sampleHoldCycles}) begin
                        stateNext   = adc_mode_pkg::ST_CONVERT;
                        stepCntNext = 8'h00;
                        resultNext  = 10'h000;
                    end
                end
            end
            adc_mode_pkg::ST_CONVERT: begin
                if (periodEnd) begin
                    stepCntNext = stepCntReg + 8'h01;
                    resultNext[9 - stepCntReg[3:0]] = compareBit;
                    if (stepCntReg == (cfg.reducedResolutionSelect ?
                            8'(adc_mode_pkg::REDUCED_RESOLUTION_SELECT_BITS - 1) :
                            8'(adc_mode_pkg::RESULT_BITS - 1))) begin
                        stateNext = adc_mode_pkg::ST_IDLE;
                        doneNext  = 1'b1;
                        sleepArmNext = cfg.sleepSelect;
                        if (cfg.reducedResolutionSelect) begin
                            resultNext = {2'b00, resultNext[9:2]};
                        end
                    end
                end
            end
            default: stateNext = adc_mode_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stateReg    <= adc_mode_pkg::ST_OFF;
            stepCntReg  <= 8'h00;
            resultReg   <= 10'h000;
            doneReg     <= 1'b0;
            sleepArmReg <= 1'b0;
        end else begin
            stateReg    <= stateNext;
            stepCntReg  <= stepCntNext;
            resultReg   <= resultNext;
            doneReg     <= doneNext;
            sleepArmReg <= sleepArmNext;
        end
    end

    assign converterClock = cclkReg;
    assign sampleHold     = stateReg == adc_mode_pkg::ST_HOLD;
    assign coreSleep      = stateReg == adc_mode_pkg::ST_OFF;
    assign conversionDone = doneReg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_DIV_TOGGLE: assert property (@(posedge ref_clk)
        disable iff (!rst_b) tick |=> cclkReg != $past(cclkReg))
        else $error("converter clock did not toggle on divider tick");
    AST_DIV_RANGE: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        divCntReg <= {1'b0, cfg.convClockDivider} || $changed(modeReg))
        else $error("divider count beyond programmed value");
    AST_STARTUP_GAP: assert property (@(posedge ref_clk)
        disable iff (!rst_b) $rose(stateReg == adc_mode_pkg::ST_IDLE) &&
        $past(stateReg) == adc_mode_pkg::ST_STARTUP |->
        stepCntReg == 8'((cfg.startupField + 6'h01) * 8))
        else $error("startup left with wrong period count");
    AST_HOLD_LEN: assert property (@(posedge ref_clk)
        disable iff (!rst_b) $past(stateReg) == adc_mode_pkg::ST_HOLD &&
        stateReg == adc_mode_pkg::ST_CONVERT |->
        $past(stepCntReg) == {4'h0, cfg.sampleHoldCycles})
        else $error("hold phase length wrong");
    AST_SLEEP_OFF: assert property (@(posedge ref_clk)
        disable iff (!rst_b) coreSleep && !cfg.sleepSelect |=>
        stateReg == adc_mode_pkg::ST_STARTUP)
        else $error("normal mode did not wake the core");
    AST_RES_LEN: assert property (@(posedge ref_clk)
        disable iff (!rst_b) doneReg |->
        $past(stepCntReg) == (cfg.reducedResolutionSelect ? 8'h07 : 8'h09))
        else $error("conversion bit count wrong for resolution");
    AST_REDUCED_RESOLUTION_SELECT_TOP: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        doneReg && cfg.reducedResolutionSelect |-> resultReg[9:8] == 2'b00)
        else $error("8-bit result has upper bits set");
    AST_HW_START: assert property (@(posedge ref_clk)
        disable iff (!rst_b) stateReg == adc_mode_pkg::ST_IDLE &&
        !sleepArmReg && cfg.hwTriggerEnable && trigEdge |=>
        stateReg == adc_mode_pkg::ST_HOLD)
        else $error("trigger edge did not start conversion");
    AST_NO_SW_START: assert property (@(posedge ref_clk)
        disable iff (!rst_b) stateReg == adc_mode_pkg::ST_IDLE &&
        cfg.hwTriggerEnable && !trigEdge |=> stateReg != adc_mode_pkg::ST_HOLD)
        else $error("conversion started without selected trigger");
    AST_SLEEP_AFTER: assert property (@(posedge ref_clk)
        disable iff (!rst_b) doneReg && cfg.sleepSelect &&
        $past(cfg.sleepSelect) |=> coreSleep)
        else $error("sleep not entered after conversion");
    AST_MODE_WR: assert property (@(posedge ref_clk)
        disable iff (!rst_b) wrEn && paddr == adc_mode_pkg::MODE_CFG_OFFSET |=>
        modeReg == ($past(pwdata) & 32'h0F1F_3F3F))
        else $error("mode register write lost");
endmodule

// ### design/adc_mode_pkg.sv
// Package for the converter mode and timing control block.
// Assumes a single 125 MHz clock domain and an APB register port.
package adc_mode_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0]  MODE_CFG_OFFSET   = 8'h04;
    localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET     = 8'h08;
    localparam logic [7:0]  RESULT_OFFSET     = 8'h0C;
    localparam logic [31:0] MODE_CFG_RESET    = 32'h0000_0000;
    localparam logic [31:0] MODE_CFG_MASK     = 32'h0F1F_3F3F;

    // ****************************************************************
    // Mode register field positions
    // ****************************************************************
    localparam int TRIG_EN_POS  = 0;
    localparam int TRIG_SEL_LSB = 1;
    localparam int RES_POS      = 4;
    localparam int SLEEP_POS    = 5;
    localparam int DIV_LSB      = 8;
    localparam int START_LSB    = 16;
    localparam int HOLD_LSB     = 24;

    localparam int NUM_TRIGGERS    = 5;
    localparam int STARTUP_MULT    = 8;
    localparam int RESULT_BITS     = 10;
    localparam int REDUCED_RESOLUTION_SELECT_BITS     = 8;

    typedef struct packed {
        logic [3:0] sampleHoldCycles;
        logic [4:0] startupField;
        logic [5:0] convClockDivider;
        logic       sleepSelect;
        logic       reducedResolutionSelect;
        logic [2:0] triggerSourceSelect;
        logic       hwTriggerEnable;
    } mode_cfg_t;

    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_STARTUP = 3'b001,
        ST_IDLE    = 3'b011,
        ST_HOLD    = 3'b010,
        ST_CONVERT = 3'b110
    } conv_state_t;

endpackage

// ### test/analog_core_model.sv
// Behavioural model of the analog core facing the timing control block.
// Assumes converterClock ticks on its falling edge and bits go MSB first.
`timescale 1ns/1ps
module analog_core_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       converterClock,
    input  wire logic       sampleHold,
    input  wire logic [9:0] pattern,
    output logic            compareBit
);
    logic       ccLast;
    logic [4:0] tickCnt;
    logic       noise;

    // Ticks are seen one edge late so the answer never races the sample
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ccLast  <= 1'h0;
            tickCnt <= 5'h1F;
            noise   <= 1'h0;
        end else begin
            ccLast <= converterClock;
            noise  <= ~noise;
            if (sampleHold) begin
                tickCnt <= 5'h00;
            end else if (ccLast && !converterClock && tickCnt != 5'h1F) begin
                tickCnt <= tickCnt + 5'h01;
            end
        end
    end

    // Outside a conversion the line toggles so a stale value cannot pass
    assign compareBit = (tickCnt >= 5'h01 && tickCnt <= 5'h0A) ?
        pattern[4'(5'h0A - tickCnt)] : noise;
endmodule

// ### test/test_adc_mode_timing_control.sv
// Self-checking bench for the converter mode and timing control block.
// Assumes the analog core model on the far side and APB at 125 MHz.
`timescale 1ns/1ps
module test_adc_mode_timing_control;
    localparam logic [7:0] MODE = adc_mode_pkg::MODE_CFG_OFFSET;
    localparam logic [7:0] CTRL = adc_mode_pkg::CTRL_OFFSET;
    localparam logic [7:0] RES  = adc_mode_pkg::RESULT_OFFSET;
    logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  intTrigger;
    logic [9:0]  pattern;
    logic        compareBit, converterClock, sampleHold, coreSleep;
    logic        conversionDone, err;
    int          mismatches, cmp_count, cycles, n;

    adc_mode_timing_control dut (
        .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .intTrigger, .compareBit,
        .converterClock, .sampleHold, .coreSleep, .conversionDone
    );
    analog_core_model core (
        .ref_clk, .rst_b, .converterClock, .sampleHold, .pattern, .compareBit
    );

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            end_of_test();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
        end
    endtask
    task automatic rng(string nm, int lo, int hi, int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d",
                     nm, lo, hi, got);
        end
    endtask
    function automatic logic [31:0] mw(int te, int ts, int lr, int sl,
                                       int dv, int su, int sh);
        mw = {4'h0, 4'(sh), 3'h0, 5'(su), 2'h0, 6'(dv), 2'h0,
              1'(sl), 1'(lr), 3'(ts), 1'(te)};
    endfunction
    // The idle edge at the end keeps back-to-back calls apart
    // Waits are ended only by the global cycle ceiling
    task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        @(posedge ref_clk);
        while (pready !== 1'h1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask
    function automatic logic sig(int s);
        case (s)
            0: return converterClock;
            1: return sampleHold;
            2: return coreSleep;
            default: return conversionDone;
        endcase
    endfunction
    task automatic waitSig(int s, logic v);
        n = 0;
        while (sig(s) !== v) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_regs();
        chk("awake after reset", 32'h0, {31'h0, coreSleep});
        apb(MODE, 1'h0, 32'h0);
        chk("mode reset", 32'h0, rd);
        apb(MODE, 1'h1, 32'hFFFF_FFFF);
        apb(MODE, 1'h0, 32'h0);
        chk("mode mask", 32'h0F1F_3F3F, rd);
        apb(MODE, 1'h1, mw(1, 5, 0, 1, 42, 21, 9));
        apb(MODE, 1'h0, 32'h0);
        chk("mode fields", mw(1, 5, 0, 1, 42, 21, 9), rd);
        apb(8'h10, 1'h0, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(MODE, 1'h1, 32'h0);
        $display("test regs done");
    endtask
    task automatic test_div(int d);
        int hi;
        apb(MODE, 1'h1, mw(0, 0, 0, 0, d, 0, 0));
        waitSig(0, 1'h0);
        waitSig(0, 1'h1);
        waitSig(0, 1'h0);
        hi = n;
        waitSig(0, 1'h1);
        rng("clock period", (d + 1) * 2, (d + 1) * 2, hi + n);
        $display("test divider %0d done", d);
    endtask
    task automatic conv(int lr, int d, int h, logic [31:0] ex);
        int p, b;
        p = (d + 1) * 2;
        apb(MODE, 1'h1, mw(0, 0, lr, 0, d, 0, h));
        apb(CTRL, 1'h1, 32'h1);
        waitSig(1, 1'h1);
        rng("start latency", 0, 4, n);
        waitSig(1, 1'h0);
        // First hold period may be partial: hold counts period ends
        rng("hold length", h * p + 1, (h + 1) * p, n);
        waitSig(3, 1'h1);
        b = lr ? 8 : 10;
        rng("bit periods", b * p - 1, b * p + 3, n);
        @(posedge ref_clk);
        chk("done pulse", 32'h0, {31'h0, conversionDone});
        apb(RES, 1'h0, 32'h0);
        chk("result", ex, rd);
        $display("test conversion done");
    endtask
    task automatic test_sleep();
        apb(MODE, 1'h1, mw(0, 0, 0, 1, 0, 1, 0));
        repeat (20) @(posedge ref_clk);
        chk("no sleep while idle", 32'h0, {31'h0, coreSleep});
        apb(CTRL, 1'h1, 32'h1);
        waitSig(3, 1'h1);
        waitSig(2, 1'h1);
        rng("sleep after conversion", 0, 3, n);
        apb(CTRL, 1'h1, 32'h1);
        apb(adc_mode_pkg::STATUS_OFFSET, 1'h0, 32'h0);
        chk("status asleep pending", 32'h5, rd);
        apb(MODE, 1'h1, mw(0, 0, 0, 0, 0, 1, 0));
        waitSig(1, 1'h1);
        rng("startup wait", 31, 36, n);
        waitSig(3, 1'h1);
        $display("test sleep done");
    endtask
    task automatic test_trig();
        int hits;
        for (int k = 0; k < 9; k++) begin
            apb(MODE, 1'h1, mw(int'(k < 8), k % 8, 0, 0, 0, 0, 0));
            intTrigger <= (k < 5) ? 5'(1 << ((k + 1) % 5)) : 5'h1F;
            hits = 0;
            repeat (12) begin
                @(posedge ref_clk);
                hits += int'(sampleHold === 1'h1);
            end
            intTrigger <= 5'h00;
            chk("unselected trigger", 32'h0, 32'(hits));
            if (k < 5) begin
                @(posedge ref_clk);
                intTrigger <= 5'(1 << k);
                waitSig(1, 1'h1);
                rng("trigger start", 3, 8, n);
                intTrigger <= 5'h00;
                waitSig(3, 1'h1);
            end
        end
        $display("test trigger done");
    endtask

    initial begin
        ref_clk = 1'h0;
        rst_b = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        intTrigger = 5'h00;
        pattern = 10'h2A5;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'h1;
        repeat (20) @(posedge ref_clk);
        test_regs();
        test_div(0);
        test_div(5);
        conv(0, 1, 3, 32'h2A5);
        conv(1, 1, 3, 32'hA9);
        conv(0, 0, 0, 32'h2A5);
        test_sleep();
        test_trig();
        end_of_test();
    end
endmodule
